// [rtc_core.sv]
module rtc_core #(
    parameter int unsigned VARIANT = rtc_pkg::VAR_COMBINED,
    parameter int unsigned RST_DELAY_CYCLES = rtc_pkg::RST_DELAY_CYC,
    parameter int unsigned DEBOUNCE_CYCLES = rtc_pkg::DEBOUNCE_CYC,
    parameter int unsigned OSC_START_CYCLES = rtc_pkg::OSC_START_CYC
) (
    input logic ref_clk,
    input logic rst,
    input logic bus_clk,
    input logic bus_rst,
    input logic reg_req,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    output logic reg_ready,
    output logic reg_done,
    output logic [7:0] reg_rdata,
    input logic supply_fail,
    input logic reset_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe,
    output logic combined_output_pin_o,
    output logic combined_output_pin_oe,
    output logic square_wave_pin_o,
    output logic square_wave_pin_oe,
    output logic access_blocked
);

    ////////////////////////////////////////////////////////////////////////////
    // State types

    typedef struct packed {
        logic ack_s1;
        logic ack_s2;
        logic ack_s3;
        logic req_tgl;
        logic ready;
        logic done;
        logic [7:0] rdata;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bus_state_t;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic ack_tgl;
        logic [7:0] rd_data;
        logic sf_s1;
        logic sf_s2;
        logic rp_s1;
        logic rp_s2;
        logic rp_s3;
        logic [24:0] acc;
        logic [15:0] sq_cnt;
        logic [5:0] div;
        logic [4:0] cyc;
        logic upd;
        logic [7:0][7:0] tk;
        logic [4:0][7:0] al;
        logic [7:0] ctrl;
        logic [7:0] status;
        logic [7:0] trickle;
        logic osc_run;
        rtc_pkg::rst_state_t rstate;
        logic [31:0] rcnt;
        logic comb_oe;
        logic sqw_oe;
        logic rst_oe;
        logic blocked;
    } core_state_t;

    bus_state_t b_q;
    bus_state_t b_d;
    core_state_t c_q;
    core_state_t c_d;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    function automatic logic [5:0] month_last(input logic [4:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        case (mon)
            5'h02: month_last = leap ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: month_last = 6'h30;
            default: month_last = 6'h31;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Host side of the register port

    always_comb begin
        b_d = b_q;
        b_d.done = 1'b0;
        b_d.ack_s1 = c_q.ack_tgl;
        b_d.ack_s2 = b_q.ack_s1;
        b_d.ack_s3 = b_q.ack_s2;
        if (!b_q.ready && (b_q.ack_s2 != b_q.ack_s3)) begin
            b_d.ready = 1'b1;
            b_d.done = 1'b1;
            b_d.rdata = c_q.rd_data;
        end
        if (b_q.ready && reg_req) begin
            b_d.addr = reg_addr;
            b_d.wdata = reg_wdata;
            b_d.req_tgl = ~b_q.req_tgl;
            b_d.ready = 1'b0;
        end
    end

    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            b_q <= '0;
            b_q.ready <= 1'b1;
        end else begin
            b_q <= b_d;
        end
    end

    assign reg_ready = b_q.ready;
    assign reg_done = b_q.done;
    assign reg_rdata = b_q.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Timekeeping core

    always_comb begin
        logic [25:0] acc_sum;
        logic base_tick;
        logic tick4k;
        logic hund_tick;
        logic osc_run;
        logic carry;
        logic [7:0] hr;
        logic [5:0] div_last;
        logic req_edge;
        logic [3:0] idx;
        logic [7:0] wv;
        logic [15:0][7:0] regs;
        logic hs_ok;
        logic dd_ok;
        logic match;
        logic [7:0] st_set;
        logic [7:0] st_clr;
        logic [31:0] target;
        logic powered;
        logic sq;
        logic irq;

        c_d = c_q;
        acc_sum = '0;
        base_tick = 1'b0;
        tick4k = 1'b0;
        hund_tick = 1'b0;
        carry = 1'b0;
        hr = c_q.tk[3];
        div_last = '0;
        idx = b_q.addr[3:0];
        wv = '0;
        st_set = '0;
        st_clr = '0;
        target = '0;

        c_d.req_s1 = b_q.req_tgl;
        c_d.req_s2 = c_q.req_s1;
        c_d.req_s3 = c_q.req_s2;
        c_d.sf_s1 = supply_fail;
        c_d.sf_s2 = c_q.sf_s1;
        c_d.rp_s1 = reset_pin_i;
        c_d.rp_s2 = c_q.rp_s1;
        c_d.rp_s3 = c_q.rp_s2;
        req_edge = c_q.req_s2 != c_q.req_s3;

        osc_run = !(c_q.sf_s2 && c_q.ctrl[rtc_pkg::CTRL_OSC_STOP]);
        c_d.osc_run = osc_run;
        if (c_q.osc_run && !osc_run) begin
            st_set[rtc_pkg::ST_OSF] = 1'b1;
        end

        // Exact fractional divider from the reference clock to 65536Hz
        acc_sum = {1'b0, c_q.acc} + 26'(rtc_pkg::BASE_HZ);
        if (acc_sum >= 26'(rtc_pkg::REF_HZ)) begin
            c_d.acc = 25'(acc_sum - 26'(rtc_pkg::REF_HZ));
            base_tick = osc_run;
        end else begin
            c_d.acc = acc_sum[24:0];
        end
        if (base_tick) begin
            c_d.sq_cnt = c_q.sq_cnt + 16'h0001;
            tick4k = c_q.sq_cnt[3:0] == 4'hf;
        end

        div_last = (c_q.cyc == rtc_pkg::DIV_PERIOD_LAST) ? rtc_pkg::DIV_SHORT_LAST : rtc_pkg::DIV_LONG_LAST;
        if (tick4k) begin
            if (c_q.div == div_last) begin
                c_d.div = '0;
                hund_tick = 1'b1;
                c_d.cyc = (c_q.cyc == rtc_pkg::DIV_PERIOD_LAST) ? 5'h00 : c_q.cyc + 5'h01;
            end else begin
                c_d.div = c_q.div + 6'h01;
            end
        end
        c_d.upd = hund_tick;

        // BCD counting chain
        if (hund_tick) begin
            carry = c_q.tk[0] == 8'h99;
            c_d.tk[0] = carry ? 8'h00 : bcd_inc(c_q.tk[0]);
            if (carry) begin
                carry = c_q.tk[1] == 8'h59;
                c_d.tk[1] = carry ? 8'h00 : bcd_inc(c_q.tk[1]);
            end
            if (carry) begin
                carry = c_q.tk[2] == 8'h59;
                c_d.tk[2] = carry ? 8'h00 : bcd_inc(c_q.tk[2]);
            end
            if (carry) begin
                carry = 1'b0;
                if (hr[rtc_pkg::HR_MODE12]) begin
                    if (hr[4:0] == 5'h12) begin
                        hr[4:0] = 5'h01;
                    end else if (hr[4:0] == 5'h11) begin
                        hr[4:0] = 5'h12;
                        carry = hr[rtc_pkg::HR_PM];
                        hr[rtc_pkg::HR_PM] = ~hr[rtc_pkg::HR_PM];
                    end else begin
                        hr[4:0] = 5'(bcd_inc({3'b000, hr[4:0]}));
                    end
                end else if (hr[5:0] == 6'h23) begin
                    hr[5:0] = 6'h00;
                    carry = 1'b1;
                end else begin
                    hr[5:0] = 6'(bcd_inc({2'b00, hr[5:0]}));
                end
                c_d.tk[3] = hr;
            end
            if (carry) begin
                c_d.tk[4] = (c_q.tk[4][2:0] == 3'h7) ? 8'h01 : bcd_inc(c_q.tk[4]);
                carry = c_q.tk[5][5:0] == month_last(c_q.tk[6][4:0], c_q.tk[7]);
                c_d.tk[5] = carry ? 8'h01 : bcd_inc(c_q.tk[5]);
            end
            if (carry) begin
                carry = c_q.tk[6][4:0] == 5'h12;
                c_d.tk[6][4:0] = carry ? 5'h01 : 5'(bcd_inc({3'b000, c_q.tk[6][4:0]}));
            end
            if (carry) begin
                carry = c_q.tk[7] == 8'h99;
                c_d.tk[7] = carry ? 8'h00 : bcd_inc(c_q.tk[7]);
                if (carry) begin
                    c_d.tk[6][rtc_pkg::MON_CENTURY] = ~c_q.tk[6][rtc_pkg::MON_CENTURY];
                end
            end
        end

        // Alarm compare, one cycle after the counters settle
        if (c_q.al[0] == 8'hff) begin
            hs_ok = 1'b1;
        end else if (c_q.al[0][7:4] == 4'hf) begin
            hs_ok = c_q.al[0][3:0] == c_q.tk[0][3:0];
        end else begin
            hs_ok = c_q.al[0] == c_q.tk[0];
        end
        dd_ok = c_q.al[4][rtc_pkg::AL_DAYSEL] ? (c_q.al[4][5:0] == c_q.tk[4][5:0])
                                              : (c_q.al[4][5:0] == c_q.tk[5][5:0]);
        match = hs_ok
              && (c_q.al[1][rtc_pkg::AL_MASK] || c_q.al[1][6:0] == c_q.tk[1][6:0])
              && (c_q.al[2][rtc_pkg::AL_MASK] || c_q.al[2][6:0] == c_q.tk[2][6:0])
              && (c_q.al[3][rtc_pkg::AL_MASK] || c_q.al[3][6:0] == c_q.tk[3][6:0])
              && (c_q.al[4][rtc_pkg::AL_MASK] || dd_ok);
        if (c_q.upd && match) begin
            st_set[rtc_pkg::ST_AF] = 1'b1;
        end

        // Register access, refused while a reset cycle runs
        regs = {c_q.trickle, c_q.status, c_q.ctrl, c_q.al, c_q.tk};
        if (req_edge) begin
            c_d.ack_tgl = ~c_q.ack_tgl;
            c_d.rd_data = 8'h00;
            wv = b_q.wdata & rtc_pkg::WR_MASK[idx];
            if (!c_q.blocked && b_q.addr[6:4] == 3'b000) begin
                if (b_q.addr[rtc_pkg::WRITE_BIT]) begin
                    if (idx <= rtc_pkg::ADDR_YEAR) begin
                        c_d.tk[idx[2:0]] = wv;
                    end else if (idx <= rtc_pkg::ADDR_ALARM_LAST) begin
                        c_d.al[3'(idx - rtc_pkg::ADDR_ALARM_FIRST)] = wv;
                    end else if (idx == rtc_pkg::ADDR_CTRL) begin
                        c_d.ctrl = wv;
                    end else if (idx == rtc_pkg::ADDR_STATUS) begin
                        st_clr = ~wv & rtc_pkg::WR_MASK[rtc_pkg::ADDR_STATUS];
                    end else begin
                        c_d.trickle = wv;
                    end
                end else begin
                    c_d.rd_data = regs[idx];
                end
            end
        end
        c_d.status = (c_q.status & ~st_clr) | st_set;

        // Reset and pushbutton sequencing
        target = RST_DELAY_CYCLES + (c_q.ctrl[rtc_pkg::CTRL_OSC_STOP] ? OSC_START_CYCLES : 32'h0);
        c_d.rcnt = c_q.rcnt + 32'h1;
        case (c_q.rstate)
            rtc_pkg::RS_RUN: begin
                c_d.rcnt = '0;
                if (c_q.sf_s2) begin
                    c_d.rstate = rtc_pkg::RS_FAIL;
                end else if (c_q.rp_s3 && !c_q.rp_s2) begin
                    c_d.rstate = rtc_pkg::RS_DEB1;
                end
            end
            rtc_pkg::RS_FAIL: begin
                c_d.rcnt = '0;
                if (!c_q.sf_s2) begin
                    c_d.rstate = rtc_pkg::RS_DELAY;
                end
            end
            rtc_pkg::RS_DELAY: begin
                if (c_q.sf_s2) begin
                    c_d.rstate = rtc_pkg::RS_FAIL;
                end else if (c_q.rcnt >= target - 32'h1) begin
                    c_d.rstate = rtc_pkg::RS_RUN;
                end
            end
            rtc_pkg::RS_DEB1: begin
                if (c_q.sf_s2) begin
                    c_d.rstate = rtc_pkg::RS_FAIL;
                end else if (c_q.rcnt >= DEBOUNCE_CYCLES - 32'h1) begin
                    c_d.rstate = rtc_pkg::RS_WAIT;
                end
            end
            rtc_pkg::RS_WAIT: begin
                c_d.rcnt = '0;
                if (c_q.sf_s2) begin
                    c_d.rstate = rtc_pkg::RS_FAIL;
                end else if (c_q.rp_s2) begin
                    c_d.rstate = rtc_pkg::RS_DEB2;
                end
            end
            rtc_pkg::RS_DEB2: begin
                if (c_q.sf_s2) begin
                    c_d.rstate = rtc_pkg::RS_FAIL;
                end else if (c_q.rcnt >= DEBOUNCE_CYCLES - 32'h1) begin
                    c_d.rstate = rtc_pkg::RS_RUN;
                end
            end
            default: begin
                c_d.rstate = rtc_pkg::RS_FAIL;
            end
        endcase
        c_d.blocked = c_d.rstate != rtc_pkg::RS_RUN;
        c_d.rst_oe = c_d.rstate != rtc_pkg::RS_RUN && c_d.rstate != rtc_pkg::RS_WAIT;

        // Output pins, open drain: enable high pulls low
        powered = !c_q.sf_s2 || c_q.ctrl[rtc_pkg::CTRL_BACKUP_OUT];
        case ({c_q.ctrl[rtc_pkg::CTRL_RATE_HI], c_q.ctrl[rtc_pkg::CTRL_RATE_LO]})
            2'b00: sq = c_q.sq_cnt[15];
            2'b01: sq = c_q.sq_cnt[3];
            2'b10: sq = c_q.sq_cnt[2];
            default: sq = c_q.sq_cnt[0];
        endcase
        irq = c_d.status[rtc_pkg::ST_AF] && c_q.ctrl[rtc_pkg::CTRL_AIE];
        c_d.comb_oe = 1'b0;
        c_d.sqw_oe = 1'b0;
        if (powered) begin
            if (VARIANT == rtc_pkg::VAR_COMBINED) begin
                if (c_q.ctrl[rtc_pkg::CTRL_OUT_SEL]) begin
                    c_d.comb_oe = irq;
                end else begin
                    c_d.comb_oe = osc_run && !sq;
                end
            end else if (VARIANT == rtc_pkg::VAR_SPLIT) begin
                c_d.comb_oe = irq;
                c_d.sqw_oe = !c_q.ctrl[rtc_pkg::CTRL_OUT_SEL] && osc_run && !sq;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            c_q <= '0;
            c_q.tk <= rtc_pkg::TIME_RESET;
            c_q.ctrl <= rtc_pkg::CTRL_RESET;
            c_q.status <= rtc_pkg::STATUS_RESET;
            c_q.trickle <= rtc_pkg::TRICKLE_RESET;
            c_q.osc_run <= 1'b1;
            c_q.rp_s1 <= 1'b1;
            c_q.rp_s2 <= 1'b1;
            c_q.rp_s3 <= 1'b1;
            c_q.rstate <= rtc_pkg::RS_DELAY;
            c_q.rst_oe <= 1'b1;
            c_q.blocked <= 1'b1;
        end else begin
            c_q <= c_d;
        end
    end

    assign reset_pin_o = 1'b0;
    assign reset_pin_oe = c_q.rst_oe;
    assign combined_output_pin_o = 1'b0;
    assign combined_output_pin_oe = c_q.comb_oe;
    assign square_wave_pin_o = 1'b0;
    assign square_wave_pin_oe = c_q.sqw_oe;
    assign access_blocked = c_q.blocked;

endmodule

// [rtc_core_chk.sv]
module rtc_core_chk #(
    parameter int unsigned VARIANT = 0,
    parameter int unsigned RST_DELAY_CYCLES = 200,
    parameter int unsigned OSC_START_CYCLES = 300
) (
    input logic ref_clk,
    input logic rst,
    input logic bus_clk,
    input logic bus_rst,
    input logic reg_req,
    input logic reg_ready,
    input logic reg_done,
    input logic [7:0] reg_rdata,
    input logic supply_fail,
    input logic square_wave_pin_oe,
    input logic access_blocked
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned LIM = RST_DELAY_CYCLES + OSC_START_CYCLES + 8;
    // Cycles since reset release or supply recovery, saturating
    logic [11:0] since_q;
    logic [11:0] since_d;
    always_comb begin
        since_d = since_q;
        if (supply_fail) begin
            since_d = 12'h000;
        end else if (since_q < 12'(LIM)) begin
            since_d = since_q + 12'h001;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            since_q <= 12'h000;
        end else begin
            since_q <= since_d;
        end
    end
    ////////////////////////////////////////
    chk_hold_recover: assert property (@(posedge ref_clk) disable iff (rst)
        (since_q != 12'h000 && since_q < 12'(RST_DELAY_CYCLES)) |-> access_blocked)
        else $error("access opened before recovery delay");
    chk_release_bound: assert property (@(posedge ref_clk) disable iff (rst)
        since_q == 12'(LIM) |-> !access_blocked) else $error("access still blocked");
    chk_block_fail: assert property (@(posedge ref_clk) disable iff (rst)
        supply_fail [*6] |-> access_blocked) else $error("access open during supply failure");
    chk_split_idle: assert property (@(posedge ref_clk) disable iff (rst)
        VARIANT != 2 |-> !square_wave_pin_oe) else $error("square pin driven in this variant");
    chk_take_ready: assert property (@(posedge bus_clk) disable iff (bus_rst)
        reg_req && reg_ready |=> !reg_ready) else $error("ready stayed high after request");
    chk_done_bound: assert property (@(posedge bus_clk) disable iff (bus_rst)
        reg_req && reg_ready |-> ##[2:40] reg_done) else $error("access never finished");
    chk_ready_rise: assert property (@(posedge bus_clk) disable iff (bus_rst)
        $rose(reg_ready) |-> reg_done ##1 !reg_done) else $error("ready rose without done pulse");
    chk_rdata_hold: assert property (@(posedge bus_clk) disable iff (bus_rst)
        !reg_done |-> $stable(reg_rdata)) else $error("read data changed without done");
endmodule
bind rtc_core rtc_core_chk #(.VARIANT(VARIANT), .RST_DELAY_CYCLES(RST_DELAY_CYCLES),
    .OSC_START_CYCLES(OSC_START_CYCLES)) u_chk (.ref_clk(ref_clk), .rst(rst), .bus_clk(bus_clk),
    .bus_rst(bus_rst), .reg_req(reg_req), .reg_ready(reg_ready), .reg_done(reg_done),
    .reg_rdata(reg_rdata), .supply_fail(supply_fail), .square_wave_pin_oe(square_wave_pin_oe),
    .access_blocked(access_blocked));

// [rtc_core_tb.sv]
module rtc_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int RDLY = 200;
    localparam int OSC = 300;
    localparam int WIN = 10000;
    logic ref_clk = 1'b0;
    logic bus_clk = 1'b0;
    logic rst = 1'b1;
    logic bus_rst = 1'b1;
    logic supply_fail = 1'b0;
    logic reg_req, reg_ready, reg_done, reset_pin_oe, comb_oe, sq_oe, access_blocked, ok;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, v;
    int err_total = 0;
    int total_checks = 0;
    int n, i, seed_val;
    int idx[13] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 15};
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        #2.7;
        forever #6 bus_clk = ~bus_clk;
    end
    rtc_core #(.VARIANT(0), .RST_DELAY_CYCLES(RDLY), .DEBOUNCE_CYCLES(100), .OSC_START_CYCLES(OSC)) dut (
        .ref_clk(ref_clk), .rst(rst), .bus_clk(bus_clk), .bus_rst(bus_rst), .reg_req(reg_req),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ready(reg_ready), .reg_done(reg_done),
        .reg_rdata(reg_rdata), .supply_fail(supply_fail), .reset_pin_i(~reset_pin_oe), .reset_pin_o(),
        .reset_pin_oe(reset_pin_oe), .combined_output_pin_o(), .combined_output_pin_oe(comb_oe),
        .square_wave_pin_o(), .square_wave_pin_oe(sq_oe), .access_blocked(access_blocked));
    rtc_host host (.bus_clk(bus_clk), .reg_req(reg_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_ready(reg_ready), .reg_done(reg_done), .reg_rdata(reg_rdata));
    ////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rw(input logic [7:0] a, input logic [7:0] d);
        host.access(a, d, rd, ok);
        check({7'h00, ok}, 8'h01);
    endtask
    task automatic wait_open(output int c);
        c = 0;
        while (access_blocked !== 1'b0 && c < 2000) begin
            @(negedge ref_clk);
            c++;
        end
    endtask
    task automatic count_edges(output int c);
        logic last;
        c = 0;
        // Let a new control setting reach the pin before counting
        repeat (2) @(negedge ref_clk);
        last = comb_oe;
        repeat (WIN) begin
            @(negedge ref_clk);
            if (comb_oe !== last) c++;
            last = comb_oe;
        end
    endtask
    function automatic int exp_edges(input int rs);
        int hz[4] = '{1, 4096, 8192, 32768};
        return 2 * hz[rs] * WIN / 20_000_000;
    endfunction
    function automatic logic [7:0] bcd(input int x);
        return 8'((x / 10) * 16 + x % 10);
    endfunction
    // Legal random content for one register index
    function automatic logic [7:0] pick(input int k);
        logic [7:0] pm;
        pm = 8'($urandom_range(1)) << 5;
        case (k)
            1, 2: return bcd($urandom_range(59));
            3: begin
                if ($urandom_range(1) != 0) return 8'h40 | pm | bcd($urandom_range(12, 1));
                return bcd($urandom_range(23));
            end
            4: return bcd($urandom_range(7, 1));
            5: return bcd($urandom_range(28, 1));
            6: return bcd($urandom_range(12, 1));
            7: return bcd($urandom_range(99));
            default: return 8'($urandom);
        endcase
    endfunction
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        #4_000_000;
        err_total++;
        report_and_stop();
    end
    initial begin
        seed_val = $urandom(32'h286de6c7);
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        bus_rst <= 1'b0;
        rw(8'h0d, 8'h00);
        check(rd, 8'h00);
        check({7'h00, access_blocked}, 8'h01);
        wait_open(n);
        check({7'h00, n > 100 && n <= RDLY + 8}, 8'h01);
        rw(8'h0d, 8'h00);
        check(rd, 8'h18);
        rw(8'h0e, 8'h00);
        check(rd, 8'h80);
        rw(8'h8e, 8'hff);
        rw(8'h0e, 8'h00);
        check(rd, 8'h80);
        for (int k = 0; k < 2; k++) begin
            rw(8'h8e, k == 0 ? 8'h00 : 8'h81);
            rw(8'h0e, 8'h00);
            check(rd, 8'h00);
        end
        repeat (24) begin
            i = idx[$urandom_range(12)];
            v = pick(i);
            rw(8'h80 | 8'(i), v);
            rw(8'(i), 8'h00);
            check(rd, v);
        end
        rw(8'h90, 8'h55);
        rw(8'h10, 8'h00);
        check(rd, 8'h00);
        rw(8'h00, 8'h00);
        check(rd, 8'h00);
        for (int r = 0; r < 4; r++) begin
            rw(8'h8d, 8'(r << 3));
            rw(8'h0d, 8'h00);
            check(rd, 8'(r << 3));
            count_edges(n);
            check(8'(n == exp_edges(r) + 1 ? n - 1 : n), 8'(exp_edges(r)));
        end
        rw(8'h8d, 8'h05);
        count_edges(n);
        check(8'(n), 8'h00);
        check({7'h00, comb_oe}, 8'h00);
        rw(8'h8d, 8'h80);
        rw(8'h8e, 8'h00);
        @(posedge ref_clk);
        supply_fail <= 1'b1;
        repeat (50) @(negedge ref_clk);
        check({7'h00, comb_oe}, 8'h00);
        check({7'h00, access_blocked}, 8'h01);
        check({7'h00, reset_pin_oe}, 8'h01);
        rw(8'h0d, 8'h00);
        check(rd, 8'h00);
        @(posedge ref_clk);
        supply_fail <= 1'b0;
        wait_open(n);
        check({7'h00, n >= RDLY + OSC && n <= RDLY + OSC + 8}, 8'h01);
        check({7'h00, reset_pin_oe}, 8'h00);
        rw(8'h0e, 8'h00);
        check(rd, 8'h80);
        report_and_stop();
    end
endmodule

// [rtc_host.sv]
module rtc_host (
    input logic bus_clk,
    output logic reg_req,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input logic reg_ready,
    input logic reg_done,
    input logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        reg_req = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Single-byte access; bit 7 of the address selects a write
    task automatic access(input logic [7:0] a, input logic [7:0] d, output logic [7:0] r, output logic ok);
        int n;
        n = 0;
        while (reg_ready !== 1'b1) @(negedge bus_clk);
        @(posedge bus_clk);
        reg_req <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge bus_clk);
        reg_req <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        do begin
            @(negedge bus_clk);
            n++;
        end while (reg_done !== 1'b1 && n < 40);
        ok = (reg_done === 1'b1);
        r = reg_rdata;
    endtask
endmodule

// [rtc_pkg.sv]
package rtc_pkg;

    localparam int unsigned REF_HZ = 20_000_000;
    localparam int unsigned BASE_HZ = 65536;

    localparam logic [5:0] DIV_LONG_LAST = 6'h28;
    localparam logic [5:0] DIV_SHORT_LAST = 6'h27;
    localparam logic [4:0] DIV_PERIOD_LAST = 5'h18;

    localparam int unsigned WRITE_BIT = 7;
    localparam logic [3:0] ADDR_HUND = 4'h0;
    localparam logic [3:0] ADDR_YEAR = 4'h7;
    localparam logic [3:0] ADDR_ALARM_FIRST = 4'h8;
    localparam logic [3:0] ADDR_ALARM_LAST = 4'hc;
    localparam logic [3:0] ADDR_CTRL = 4'hd;
    localparam logic [3:0] ADDR_STATUS = 4'he;
    localparam logic [3:0] ADDR_TRICKLE = 4'hf;

    localparam logic [15:0][7:0] WR_MASK = {8'hff, 8'h81, 8'hbd, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                                            8'hff, 8'h9f, 8'h3f, 8'h07, 8'h7f, 8'h7f, 8'h7f, 8'hff};

    localparam int unsigned CTRL_OSC_STOP = 7;
    localparam int unsigned CTRL_BACKUP_OUT = 5;
    localparam int unsigned CTRL_RATE_HI = 4;
    localparam int unsigned CTRL_RATE_LO = 3;
    localparam int unsigned CTRL_OUT_SEL = 2;
    localparam int unsigned CTRL_AIE = 0;
    localparam int unsigned ST_OSF = 7;
    localparam int unsigned ST_AF = 0;
    localparam int unsigned HR_MODE12 = 6;
    localparam int unsigned HR_PM = 5;
    localparam int unsigned MON_CENTURY = 7;
    localparam int unsigned AL_MASK = 7;
    localparam int unsigned AL_DAYSEL = 6;

    localparam logic [7:0] CTRL_RESET = 8'h18;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam logic [7:0] TRICKLE_RESET = 8'h00;
    localparam logic [7:0][7:0] TIME_RESET = {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

    localparam int unsigned RST_DELAY_MS = 250;
    localparam int unsigned DEBOUNCE_MS = 250;
    localparam int unsigned OSC_START_MS = 1000;
    localparam int unsigned RST_DELAY_CYC = RST_DELAY_MS * (REF_HZ / 1000);
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (REF_HZ / 1000);
    localparam int unsigned OSC_START_CYC = OSC_START_MS * (REF_HZ / 1000);

    localparam int unsigned VAR_COMBINED = 0;
    localparam int unsigned VAR_RESET = 1;
    localparam int unsigned VAR_SPLIT = 2;

    typedef enum logic [2:0] {
        RS_RUN = 3'b000,
        RS_FAIL = 3'b001,
        RS_DELAY = 3'b010,
        RS_DEB1 = 3'b011,
        RS_WAIT = 3'b100,
        RS_DEB2 = 3'b101
    } rst_state_t;

endpackage
